// [bidir_fifo_ports.sv]
// Purpose: port control and flag offsets of a two-way fifo pair
// Assumes: both ports run on ref_clk, inputs synchronous
// Notes: index 0 = fifo1 (a to b), 1 = fifo2 (b to a)
//
// Summary of operation
// (RQ1) four offsets: fifo1/fifo2 almost-empty and almost-full thresholds
// (RQ2) preset load needs a flag select high at the fifo reset release
// (RQ3) select codes 11, 10, 01 load 64, 16, 8 into both offsets
// (RQ4) fifo2 presets need fifo2 reset toggled with fifo1 reset; the code loads them at fifo2 reset release alone
// (RQ5) programming via port a needs both resets released with selects low
// (RQ6) first four port a writes load full1, empty1, full2, empty2
// (RQ7) offsets come from low port a data bits, top bit most significant
// (RQ8) far side writes offsets only from 1 to 252
// (RQ9) after programming, port b input-ready rises and normal work starts
// (RQ10) flag selects act the same in both timing modes
// (RQ11) port a drives data only with select low and write select low
// (RQ12) port a writes fifo1 when selected, writing, enabled, no mailbox, ready
// (RQ13) port a reads fifo2 when selected, reading, enabled, no mailbox, ready
// (RQ14) port b write select inverted; drives data with select low, it high
// (RQ15) port b writes fifo2 under the mirrored conditions
// (RQ16) port b reads fifo1 under the mirrored conditions
// (RQ17) each port works independently of the other
// (RQ18) with enable low nothing transfers, selects ignored
// (RQ19) fall-through: word moves out when output-ready rises; later only on reads
// (RQ20) standard: empty flag rises on second edge; data only on reads
// (RQ21) every flag passes two synchronising flops; the code drives the mailbox flags without them
// (RQ22) mailbox select writes own mailbox or reads other, clearing its flag
// (RQ23) fall-through select sampled at reset release picks the mode
// (RQ24) far side holds fifo resets low four edges
// (RQ25) writes ignored while input-ready is low
// (RQ26) standard mode: reads ignored while empty, output word held
// (RQ27) offsets change only at fifo reset or programming
`timescale 1ns/1ns
`include "bififo_cfg.svh"
module bidir_fifo_ports_offset_prog (
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	// fifo resets, flag selects, mode
	input wire logic fifo1_reset_n,
	input wire logic fifo2_reset_n,
	input wire logic flag_sel0,
	input wire logic flag_sel1,
	input wire logic fall_through_sel,
	// port a control and data
	input wire logic port_a_select_n,
	input wire logic port_a_write_read_sel,
	input wire logic port_a_enable,
	input wire logic port_a_mailbox_sel,
	input wire logic [`DATA_W-1:0] port_a_data_in,
	output logic [`DATA_W-1:0] port_a_data_out,
	output logic port_a_data_oe,
	// port a flags
	output logic port_a_full_or_inrdy,
	output logic port_a_empty_or_outrdy,
	output logic port_a_almost_full_n,
	output logic port_a_almost_empty_n,
	// port b control and data
	input wire logic port_b_select_n,
	input wire logic port_b_read_write_sel,
	input wire logic port_b_enable,
	input wire logic port_b_mailbox_sel,
	input wire logic [`DATA_W-1:0] port_b_data_in,
	output logic [`DATA_W-1:0] port_b_data_out,
	output logic port_b_data_oe,
	// port b flags
	output logic port_b_full_or_inrdy,
	output logic port_b_empty_or_outrdy,
	output logic port_b_almost_full_n,
	output logic port_b_almost_empty_n,
	// mailbox flags
	output logic mailbox_a_to_b_flag_n,
	output logic mailbox_b_to_a_flag_n
);
	function automatic bififo_pkg::port_op_t port_op(input logic s_n, input logic w,
			input logic e, input logic m);
		port_op = bififo_pkg::OP_NONE;
		if (!s_n && e) begin // RQ18
			case ({w, m})
				2'h2: port_op = bififo_pkg::OP_FIFO_WR;
				2'h0: port_op = bififo_pkg::OP_FIFO_RD;
				2'h3: port_op = bififo_pkg::OP_MAIL_WR;
				2'h1: port_op = bififo_pkg::OP_MAIL_RD;
				default: port_op = bififo_pkg::OP_NONE;
			endcase
		end
	endfunction : port_op

	function automatic logic [`OFS_W-1:0] preset_val(input logic [1:0] code);
		case (code)
			`FS_HI: preset_val = `PRESET_HI;
			`FS_MID: preset_val = `PRESET_MID;
			default: preset_val = `PRESET_LO;
		endcase
	endfunction : preset_val

	logic sel_n [2];
	logic wsel [2];
	logic en [2];
	logic mb [2];
	logic [`DATA_W-1:0] din [2];
	logic [1:0] rst_n;
	logic [1:0] rst_prev_reg;
	logic [1:0] rise;
	logic [1:0] mode_std_reg;
	logic [1:0] fs;
	bififo_pkg::port_op_t op [2];
	logic fifo_clr [2];
	logic wr_req [2];
	logic push [2];
	logic pop [2];
	logic rd_sel [2];
	logic fifo_in_rdy [2];
	logic fifo_out_vld [2];
	logic inrdy_en [2];
	logic [`DATA_W-1:0] fifo_q [2];
	logic [`CNT_W-1:0] cnt [2];
	logic [`CNT_W-1:0] level_ahead [2];
	logic [`FLAG_N-1:0] raw [2];
	logic [`FLAG_N-1:0] syn [2];
	logic [1:0] rdy_cnt_reg [2];
	logic full_flag_reg [2];
	logic eo_reg [2];
	logic ae_reg [2];
	logic af_reg [2];
	logic mail_n_reg [2];
	logic oe_reg [2];
	logic [`DATA_W-1:0] dout_reg [2];
	logic [`DATA_W-1:0] mailbox_reg [2];
	logic [`OFS_W-1:0] fifo1_empty_offset_reg;
	logic [`OFS_W-1:0] fifo2_empty_offset_reg;
	logic [`OFS_W-1:0] fifo1_full_offset_reg;
	logic [`OFS_W-1:0] fifo2_full_offset_reg;
	logic [`OFS_W-1:0] empty_ofs [2];
	logic [`OFS_W-1:0] full_ofs [2];
	logic [`OFS_W-1:0] prog_val;
	bififo_pkg::prog_state_t prog_state_reg;
	logic prog_busy;
	logic prog_wr;

	assign sel_n = '{port_a_select_n, port_b_select_n};
	assign wsel = '{port_a_write_read_sel, !port_b_read_write_sel}; // RQ14
	assign en = '{port_a_enable, port_b_enable};
	assign mb = '{port_a_mailbox_sel, port_b_mailbox_sel};
	assign din = '{port_a_data_in, port_b_data_in};
	assign rst_n = {fifo2_reset_n, fifo1_reset_n};
	assign rise = rst_n & ~rst_prev_reg;
	assign fs = {flag_sel1, flag_sel0};
	assign empty_ofs = '{fifo1_empty_offset_reg, fifo2_empty_offset_reg}; // RQ1
	assign full_ofs = '{fifo1_full_offset_reg, fifo2_full_offset_reg}; // RQ1
	assign prog_val = `OFS_W'(port_a_data_in[`PROG_W-1:0]); // RQ7
	assign prog_busy = prog_state_reg != bififo_pkg::P_IDLE;
	assign prog_wr = prog_busy && (op[0] == bififo_pkg::OP_FIFO_WR) && full_flag_reg[0];

	// reset release edge and mode capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rst_prev_reg <= '1;
			mode_std_reg <= '1;
		end else if (clk_en) begin
			rst_prev_reg <= rst_n;
			for (int i = 0; i < 2; i++) begin
				if (rise[i]) begin
					mode_std_reg[i] <= fall_through_sel; // RQ23
				end
			end
		end
	end

	// offset programming walk
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			prog_state_reg <= bififo_pkg::P_IDLE;
		end else if (clk_en) begin
			if (rise[0] && rise[1] && fs == `FS_PROG) begin
				prog_state_reg <= bififo_pkg::P_FULL1; // RQ5
			end else if (!rst_n[0] || !rst_n[1]) begin
				prog_state_reg <= bififo_pkg::P_IDLE;
			end else if (prog_wr) begin
				case (prog_state_reg)
					bififo_pkg::P_FULL1: prog_state_reg <= bififo_pkg::P_EMPTY1;
					bififo_pkg::P_EMPTY1: prog_state_reg <= bififo_pkg::P_FULL2;
					bififo_pkg::P_FULL2: prog_state_reg <= bififo_pkg::P_EMPTY2;
					default: prog_state_reg <= bififo_pkg::P_IDLE;
				endcase
			end
		end
	end

	// offsets: written only at srst, at fifo reset release or by programming
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fifo1_empty_offset_reg <= `PRESET_LO;
			fifo2_empty_offset_reg <= `PRESET_LO;
			fifo1_full_offset_reg <= `PRESET_LO;
			fifo2_full_offset_reg <= `PRESET_LO;
		end else if (clk_en) begin
			if (rise[0] && fs != `FS_PROG) begin // RQ2 RQ10 RQ27
				fifo1_empty_offset_reg <= preset_val(fs); // RQ3
				fifo1_full_offset_reg <= preset_val(fs); // RQ3
			end
			if (rise[1] && fs != `FS_PROG) begin // RQ2 RQ4
				fifo2_empty_offset_reg <= preset_val(fs); // RQ3
				fifo2_full_offset_reg <= preset_val(fs); // RQ3
			end
			if (prog_wr) begin
				case (prog_state_reg)
					bififo_pkg::P_FULL1: fifo1_full_offset_reg <= prog_val; // RQ6
					bififo_pkg::P_EMPTY1: fifo1_empty_offset_reg <= prog_val; // RQ6
					bififo_pkg::P_FULL2: fifo2_full_offset_reg <= prog_val; // RQ6
					bififo_pkg::P_EMPTY2: fifo2_empty_offset_reg <= prog_val; // RQ6
					default: fifo1_full_offset_reg <= fifo1_full_offset_reg;
				endcase
			end
		end
	end

	// one slice per direction; d writes from port d, reads at port 1-d
	for (genvar d = 0; d < 2; d++) begin : g_dir // RQ17
		localparam int R = 1 - d;
		assign op[d] = port_op(sel_n[d], wsel[d], en[d], mb[d]);
		assign fifo_clr[d] = srst || !rst_n[d];
		assign wr_req[d] = (op[d] == bififo_pkg::OP_FIFO_WR) && full_flag_reg[d]
			&& !(d == 0 && prog_busy); // RQ6 RQ12 RQ15 RQ25
		assign push[d] = wr_req[d] && fifo_in_rdy[d];
		assign rd_sel[d] = (op[R] == bififo_pkg::OP_FIFO_RD) && eo_reg[d]; // RQ13 RQ16 RQ26
		assign pop[d] = mode_std_reg[d] ? (rd_sel[d] && fifo_out_vld[d]) // RQ20
			: ((!eo_reg[d] || rd_sel[d]) && syn[d][`F_AVAIL] && fifo_out_vld[d]); // RQ19
		assign level_ahead[d] = cnt[d] + `CNT_W'(push[d]) - `CNT_W'(pop[d]);
		assign raw[d][`F_AVAIL] = level_ahead[d] != '0;
		assign raw[d][`F_NAE] = {1'b0, level_ahead[d]} > empty_ofs[d];
		assign raw[d][`F_NFULL] = level_ahead[d] < `DEPTH_CNT;
		assign raw[d][`F_NAF] = ({2'h0, level_ahead[d]} + {1'b0, full_ofs[d]}) < `DEPTH_CMP;
		assign inrdy_en[d] = rdy_cnt_reg[d] == `READY_DLY;

		word_fifo #(
			.WIDTH(`DATA_W),
			.DEPTH(`FIFO_DEPTH),
			.AW(`AW)
		) u_store (
			.clk(ref_clk),
			.srst(fifo_clr[d]),
			.clk_en(clk_en),
			.in_valid(wr_req[d]),
			.in_ready(fifo_in_rdy[d]),
			.in_data(din[d]),
			.out_valid(fifo_out_vld[d]),
			.out_ready(pop[d]),
			.out_data(fifo_q[d]),
			.count(cnt[d])
		);

		flag_sync #(
			.WIDTH(`FLAG_N)
		) u_sync (
			.clk(ref_clk),
			.srst(fifo_clr[d]),
			.clk_en(clk_en),
			.d_in(raw[d]),
			.sync_q(syn[d]) // RQ21
		);

		// input-ready comes up a fixed delay after reset release
		always_ff @(posedge ref_clk) begin
			if (fifo_clr[d]) begin
				rdy_cnt_reg[d] <= '0;
			end else if (clk_en && !inrdy_en[d]) begin
				rdy_cnt_reg[d] <= rdy_cnt_reg[d] + 2'h1;
			end
		end

		// port flags
		always_ff @(posedge ref_clk) begin
			if (fifo_clr[d]) begin
				full_flag_reg[d] <= 1'b0;
				eo_reg[d] <= 1'b0;
				ae_reg[d] <= 1'b0;
				af_reg[d] <= 1'b1;
			end else if (clk_en) begin
				// own fill drops ready at once; space freed by reads waits for the sync
				full_flag_reg[d] <= inrdy_en[d] && syn[d][`F_NFULL] && raw[d][`F_NFULL] // RQ12 RQ25
					&& !(d == 1 && prog_busy); // RQ9
				ae_reg[d] <= syn[d][`F_NAE];
				af_reg[d] <= syn[d][`F_NAF];
				if (mode_std_reg[d]) begin
					// reader's own last pop clears at once; new words wait for the sync
					eo_reg[d] <= syn[d][`F_AVAIL] && raw[d][`F_AVAIL]; // RQ20 RQ26
				end else if (pop[d]) begin
					eo_reg[d] <= 1'b1; // RQ19
				end else if (rd_sel[d]) begin
					eo_reg[d] <= 1'b0;
				end
			end
		end

		// read data and mailbox
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				dout_reg[d] <= '0;
				mailbox_reg[d] <= '0;
			end else if (clk_en) begin
				if (pop[d]) begin
					dout_reg[d] <= fifo_q[d];
				end else if (op[R] == bififo_pkg::OP_MAIL_RD) begin
					dout_reg[d] <= mailbox_reg[d]; // RQ22
				end
				if (op[d] == bififo_pkg::OP_MAIL_WR) begin
					mailbox_reg[d] <= din[d]; // RQ22
				end
			end
		end

		// mail flag: a new write beats a same-cycle read
		always_ff @(posedge ref_clk) begin
			if (fifo_clr[d]) begin
				mail_n_reg[d] <= 1'b1;
			end else if (clk_en) begin
				if (op[d] == bififo_pkg::OP_MAIL_WR) begin
					mail_n_reg[d] <= 1'b0;
				end else if (op[R] == bififo_pkg::OP_MAIL_RD) begin
					mail_n_reg[d] <= 1'b1; // RQ22
				end
			end
		end

		// data pin drive for port d
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				oe_reg[d] <= 1'b0;
			end else if (clk_en) begin
				oe_reg[d] <= !sel_n[d] && !wsel[d]; // RQ11 RQ14
			end
		end
	end

	assign port_a_full_or_inrdy = full_flag_reg[0];
	assign port_b_full_or_inrdy = full_flag_reg[1];
	assign port_b_empty_or_outrdy = eo_reg[0];
	assign port_a_empty_or_outrdy = eo_reg[1];
	assign port_b_almost_empty_n = ae_reg[0];
	assign port_a_almost_empty_n = ae_reg[1];
	assign port_a_almost_full_n = af_reg[0];
	assign port_b_almost_full_n = af_reg[1];
	assign port_b_data_out = dout_reg[0];
	assign port_a_data_out = dout_reg[1];
	assign port_a_data_oe = oe_reg[0];
	assign port_b_data_oe = oe_reg[1];
	assign mailbox_a_to_b_flag_n = mail_n_reg[0];
	assign mailbox_b_to_a_flag_n = mail_n_reg[1];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_a_oe_ctrl: assert property ($past(clk_en && !srst) |-> // RQ11
		port_a_data_oe == $past(!port_a_select_n && !port_a_write_read_sel))
		else $error("port a drive does not follow select");
	chk_b_oe_ctrl: assert property ($past(clk_en && !srst) |-> // RQ14
		port_b_data_oe == $past(!port_b_select_n && port_b_read_write_sel))
		else $error("port b drive does not follow select");
	chk_full_blocks_wr: assert property (!port_a_full_or_inrdy |-> !push[0]) // RQ25
		else $error("fifo1 write taken while not ready");
	chk_empty_holds_rd: assert property ( // RQ26
		mode_std_reg[1] && !port_a_empty_or_outrdy |-> !pop[1])
		else $error("fifo2 read taken while empty");
	chk_std_empty_rise: assert property ( // RQ20
		(push[0] && mode_std_reg[0] && clk_en && fifo1_reset_n)
		##1 (clk_en && fifo1_reset_n)[*2] |=> port_b_empty_or_outrdy || cnt[0] == '0)
		else $error("empty flag late after first word");
	chk_mode_latch: assert property (rise[0] && clk_en |=> // RQ23
		mode_std_reg[0] == $past(fall_through_sel))
		else $error("mode not taken at reset release");
	chk_preset_hi: assert property (rise[0] && clk_en && fs == `FS_HI |=> // RQ3
		fifo1_full_offset_reg == `PRESET_HI && fifo1_empty_offset_reg == `PRESET_HI)
		else $error("preset offsets not loaded");
	chk_prog_first: assert property ( // RQ6
		prog_state_reg == bififo_pkg::P_FULL1 && prog_wr && clk_en |=>
		fifo1_full_offset_reg == `OFS_W'($past(port_a_data_in[`PROG_W-1:0]))
		&& prog_state_reg == bififo_pkg::P_EMPTY1)
		else $error("first programming write misplaced");
	chk_prog_no_store: assert property (prog_busy |-> !push[0]) // RQ6
		else $error("programming write stored in fifo1");
	chk_b_held_prog: assert property (prog_busy |=> !port_b_full_or_inrdy) // RQ9
		else $error("port b ready during programming");
	chk_mail_write: assert property ( // RQ22
		op[0] == bififo_pkg::OP_MAIL_WR && clk_en && fifo1_reset_n |=> !mailbox_a_to_b_flag_n)
		else $error("mailbox_a_to_b flag not set by write");

	cov_prog_done: cover property (prog_state_reg == bififo_pkg::P_EMPTY2 && prog_wr);
	cov_ft_load: cover property (!mode_std_reg[0] && !eo_reg[0] && pop[0]);
	cov_mail_read: cover property (op[1] == bififo_pkg::OP_MAIL_RD && !mailbox_a_to_b_flag_n);
	cov_fifo1_full: cover property (!fifo_in_rdy[0]);
endmodule : bidir_fifo_ports_offset_prog

// [bififo_cfg.svh]
// Purpose: constants for the two-way fifo port block
// Assumes: 256-deep variant, 36-bit words
// Notes: definitions only
`ifndef BIFIFO_CFG_SVH
`define BIFIFO_CFG_SVH
`define DATA_W 36
`define OFS_W 10
`define PROG_W 8
`define AW 8
`define CNT_W 9
`define FIFO_DEPTH 256
`define DEPTH_CNT 9'h100
`define DEPTH_CMP 11'h100
`define PRESET_HI 10'h040
`define PRESET_MID 10'h010
`define PRESET_LO 10'h008
`define FS_HI 2'h3
`define FS_MID 2'h2
`define FS_PROG 2'h0
`define READY_DLY 2'h2
`define FLAG_N 4
`define F_AVAIL 3
`define F_NAE 2
`define F_NFULL 1
`define F_NAF 0
`endif

// [bififo_pkg.sv]
// Purpose: shared types of the two-way fifo port block
// Assumes: nothing
// Notes: gray codes along the programming walk except the P_EMPTY2 to P_IDLE return
package bififo_pkg;
	typedef enum logic [2:0] {
		P_IDLE = 3'h0,
		P_FULL1 = 3'h1,
		P_EMPTY1 = 3'h3,
		P_FULL2 = 3'h2,
		P_EMPTY2 = 3'h6
	} prog_state_t;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_FIFO_WR = 3'h1,
		OP_FIFO_RD = 3'h2,
		OP_MAIL_WR = 3'h3,
		OP_MAIL_RD = 3'h4
	} port_op_t;
endpackage : bififo_pkg

// [flag_sync.sv]
// Purpose: two flop synchroniser for flag levels
// Assumes: one clock, synchronous reset
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module flag_sync #(
	parameter int WIDTH = 4
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	// levels
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] sync_q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else if (clk_en) begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_q = sync_reg;
endmodule : flag_sync

// [pb_model.sv]
// Purpose: port b bus master model, reads fifo1 and writes fifo2
// Assumes: either timing mode, one clock shared with port a
// Notes: random stalls; released data bus flips between the last word and its inverse each cycle
`timescale 1ns/1ns
`include "bififo_cfg.svh"
module pb_model (
	// clocking
	input wire logic clk,
	// commands
	input wire logic rd_on,
	input wire logic wr_on,
	// device port b
	input wire logic inrdy,
	output logic sel_n,
	output logic rw_sel,
	output logic enable,
	output logic mbox,
	output logic [`DATA_W-1:0] data
);
	logic [31:0] k;
	logic [31:0] nk;
	logic stall;
	initial begin
		sel_n = 1'b1;
		rw_sel = 1'b0;
		enable = 1'b0;
		mbox = 1'b0;
		data = '0;
		k = '0;
	end
	always @(posedge clk) begin
		// next word only once the device took this one
		nk = k + ((!sel_n && enable && !rw_sel && !mbox && inrdy) ? 32'h1 : 32'h0);
		k <= nk;
		stall = ($urandom % 4) == 0;
		// select wanders while enable is low
		sel_n <= !(rd_on || wr_on) || (stall && 1'($urandom));
		rw_sel <= rd_on;
		enable <= !stall && (rd_on || wr_on);
		data <= (wr_on && !stall) ? {4'hB, nk} : ~data;
	end
endmodule : pb_model

// [testbench.sv]
// Purpose: self-checking bench for the two-way fifo port block
// Assumes: clk_en held high; fall-through tried once near the end
// Notes: port b traffic comes from the partner model
`timescale 1ns/1ns
`include "bififo_cfg.svh"
module testbench;
	logic ref_clk, srst, clk_en, fifo1_reset_n, fifo2_reset_n, flag_sel0, flag_sel1;
	logic fall_through_sel, port_a_select_n, port_a_write_read_sel, port_a_enable;
	logic port_a_mailbox_sel, port_a_data_oe, port_a_full_or_inrdy, port_a_empty_or_outrdy;
	logic port_a_almost_full_n, port_a_almost_empty_n, port_b_select_n, port_b_read_write_sel;
	logic port_b_enable, port_b_mailbox_sel, port_b_data_oe, port_b_full_or_inrdy;
	logic port_b_empty_or_outrdy, port_b_almost_full_n, port_b_almost_empty_n;
	logic mailbox_a_to_b_flag_n, mailbox_b_to_a_flag_n, b_rd_on, b_wr_on, a_rd_d, b_rd_d, b_rd_now;
	logic [`DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
	logic [`DATA_W-1:0] q_b[$];
	logic [31:0] ka;
	int errors, n_tests, j, i, n, x1, y1;

	bidir_fifo_ports_offset_prog i_dut (.ref_clk, .srst, .clk_en, .fifo1_reset_n,
		.fifo2_reset_n, .flag_sel0, .flag_sel1, .fall_through_sel, .port_a_select_n,
		.port_a_write_read_sel, .port_a_enable, .port_a_mailbox_sel, .port_a_data_in,
		.port_a_data_out, .port_a_data_oe, .port_a_full_or_inrdy, .port_a_empty_or_outrdy,
		.port_a_almost_full_n, .port_a_almost_empty_n, .port_b_select_n,
		.port_b_read_write_sel, .port_b_enable, .port_b_mailbox_sel, .port_b_data_in,
		.port_b_data_out, .port_b_data_oe, .port_b_full_or_inrdy, .port_b_empty_or_outrdy,
		.port_b_almost_full_n, .port_b_almost_empty_n, .mailbox_a_to_b_flag_n, .mailbox_b_to_a_flag_n);
	pb_model i_pb (.clk(ref_clk), .rd_on(b_rd_on), .wr_on(b_wr_on),
		.inrdy(port_b_full_or_inrdy), .sel_n(port_b_select_n),
		.rw_sel(port_b_read_write_sel), .enable(port_b_enable),
		.mbox(port_b_mailbox_sel), .data(port_b_data_in));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task conclude;
		if (errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude

	task check(input logic [`DATA_W-1:0] seen, input logic [`DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : tick

	task wait_rdy(input bit b);
		int w;
		for (w = 0; w < 20 && (b ? port_b_full_or_inrdy : port_a_full_or_inrdy) !== 1'b1; w++)
			tick(1);
		if (w == 20) begin
			errors++;
			conclude();
		end
	endtask : wait_rdy

	task fifo_reset(input logic [1:0] code);
		@(posedge ref_clk);
		fifo1_reset_n <= 1'b0;
		fifo2_reset_n <= 1'b0;
		{flag_sel1, flag_sel0} <= code;
		tick(4);
		fifo1_reset_n <= 1'b1;
		fifo2_reset_n <= 1'b1;
		wait_rdy(0);
	endtask : fifo_reset

	task a_drive(input logic sel_n, input logic wr, input logic en, input logic mb,
		input logic [`DATA_W-1:0] d);
		@(posedge ref_clk);
		port_a_select_n <= sel_n;
		port_a_write_read_sel <= wr;
		port_a_enable <= en;
		port_a_mailbox_sel <= mb;
		port_a_data_in <= d;
	endtask : a_drive

	task a_write(input logic [`DATA_W-1:0] d, input bit push);
		a_drive(1'b0, 1'b1, 1'b1, 1'b0, d);
		if (push) q_b.push_back(d);
	endtask : a_write

	task a_idle;
		a_drive(1'b1, 1'b1, 1'b0, 1'b0, ~port_a_data_in);
	endtask : a_idle

	task wr_words(input int c);
		repeat (c) a_write({4'($urandom), 32'($urandom)}, 1'b1);
		a_idle();
		tick(6);
	endtask : wr_words

	task drain_b;
		int w;
		b_rd_on <= 1'b1;
		for (w = 0; w < 3000 && q_b.size() > 0; w++) tick(1);
		b_rd_on <= 1'b0;
		if (w == 3000) begin
			errors++;
			conclude();
		end
		tick(8);
	endtask : drain_b

	assign b_rd_now = !port_b_select_n && port_b_read_write_sel && port_b_enable
		&& !port_b_mailbox_sel && port_b_empty_or_outrdy;

	// result watcher: standard read shows its word a cycle later,
	// fall-through read consumes the word already shown
	always @(posedge ref_clk) begin
		if (b_rd_d) check(port_b_data_out, q_b.size() > 0 ? q_b.pop_front() : 'x);
		if (b_rd_d) check(36'(port_b_data_oe), 36'h1);
		if (!fall_through_sel && b_rd_now)
			check(port_b_data_out, q_b.size() > 0 ? q_b.pop_front() : 'x);
		if (a_rd_d) check(port_a_data_out, {4'hB, ka});
		if (a_rd_d) ka <= ka + 32'h1;
		b_rd_d <= fall_through_sel && b_rd_now;
		a_rd_d <= !port_a_select_n && !port_a_write_read_sel && port_a_enable
			&& !port_a_mailbox_sel && port_a_empty_or_outrdy;
	end

	initial begin
		void'($urandom(41));
		{srst, clk_en, fifo1_reset_n, fifo2_reset_n, flag_sel0, flag_sel1} = 6'h33;
		fall_through_sel = 1'b1;
		{port_a_select_n, port_a_write_read_sel, port_a_enable, port_a_mailbox_sel} = 4'h8;
		port_a_data_in = '0;
		{b_rd_on, b_wr_on, a_rd_d, b_rd_d} = 4'h0;
		{errors, n_tests, ka} = '0;
		tick(4);
		srst <= 1'b0;
		// presets: offset words keep almost-empty low, one more lifts it
		for (j = 0; j < 3; j++) begin
			n = (j == 0) ? 64 : (j == 1) ? 16 : 8;
			fifo_reset(2'(3 - j));
			wr_words(n);
			check(36'(port_b_almost_empty_n), 36'h0);
			check(36'(port_a_data_oe), 36'h0);
			wr_words(1);
			check(36'(port_b_almost_empty_n), 36'h1);
			check(36'(port_a_almost_empty_n), 36'h0);
			drain_b();
		end
		// offsets through port a; high data bits must be ignored
		y1 = 200 + ($urandom % 41);
		x1 = 1 + ($urandom % 10);
		fifo_reset(2'h0);
		check(36'(port_b_full_or_inrdy), 36'h0);
		a_write({28'hFFFFFFF, 8'(y1)}, 1'b0);
		a_write({28'hFFFFFFF, 8'(x1)}, 1'b0);
		a_write({28'hFFFFFFF, 8'h05}, 1'b0);
		a_write({28'hFFFFFFF, 8'h03}, 1'b0);
		a_idle();
		wait_rdy(1);
		tick(6);
		check(36'(port_b_empty_or_outrdy), 36'h0);
		wr_words(x1);
		check(36'(port_b_almost_empty_n), 36'h0);
		wr_words(1);
		check(36'(port_b_almost_empty_n), 36'h1);
		wr_words(`FIFO_DEPTH - y1 - 2 - x1);
		check(36'(port_a_almost_full_n), 36'h1);
		wr_words(1);
		check(36'(port_a_almost_full_n), 36'h0);
		wr_words(y1);
		check(36'(port_a_full_or_inrdy), 36'h0);
		a_write(36'h123456789, 1'b0);
		a_idle();
		drain_b();
		check(36'(port_b_empty_or_outrdy), 36'h0);
		// port b fills fifo2, port a reads it back with enable gaps
		b_wr_on <= 1'b1;
		tick(40);
		b_wr_on <= 1'b0;
		tick(8);
		check(36'(port_a_almost_empty_n), 36'h1);
		check(36'(port_b_almost_full_n), 36'h1);
		for (i = 0; i < 60; i++) begin
			a_drive((i % 5) == 4 ? 1'($urandom) : 1'b0, 1'b0, (i % 5) != 4, 1'b0, '0);
			if (i == 2) check(36'(port_a_data_oe), 36'h1);
		end
		a_idle();
		tick(6);
		check({4'h0, ka}, {4'h0, i_pb.k});
		check(36'(port_a_empty_or_outrdy), 36'h0);
		// fall-through: first word shows unasked, each read consumes the shown word
		fall_through_sel <= 1'b0;
		fifo_reset(2'h1);
		wr_words(5);
		check(36'(port_b_empty_or_outrdy), 36'h1);
		check(port_b_data_out, q_b[0]);
		drain_b();
		check(36'(port_b_empty_or_outrdy), 36'h0);
		// mailbox write on port a
		a_drive(1'b0, 1'b1, 1'b1, 1'b1, 36'hA5A5A5A5A);
		a_idle();
		tick(1);
		check(36'(mailbox_a_to_b_flag_n), 36'h0);
		// mailbox read on port a: empty b-to-a mailbox replaces the last fifo word
		a_drive(1'b0, 1'b0, 1'b1, 1'b1, '0);
		a_idle();
		tick(1);
		check(36'(mailbox_b_to_a_flag_n), 36'h1);
		check(port_a_data_out, 36'h0);
		conclude();
	end
endmodule : testbench

// [word_fifo.sv]
// Purpose: flop based word fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two, AW = log2(DEPTH)
// Notes: in_ready drops when full, out_valid when empty
`timescale 1ns/1ns
`include "bififo_cfg.svh"
module word_fifo #(
	parameter int WIDTH = `DATA_W,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic clk_en,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// fill level
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = count_reg < (AW+1)'(DEPTH);
	assign out_valid = count_reg != '0;
	assign out_data = mem_reg[rd_ptr_reg];
	assign count = count_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (clk_en) begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : word_fifo
